// file: src/lusc_interlock.sv
/*
 * Issue interlock for the data side: load-use scoreboard, fill buffer and
 * pending buffer tracking, write buffer occupancy and the issue stall.
 * Assumes the memory interface runs on sys_clk and reports each finished
 * line fill and each drained write buffer as a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none

`include "lusc_cfg.svh"

// Notes on behaviour
// - a word load that hits makes its value usable three cycles after it issues.
// - an instruction right after a hitting load that reads its result waits two cycles.
// - a missing load keeps its destination busy until the line fill returns.
// - four fill buffers exist, one taken for each load or preload miss to a line not already being filled.
// - issue stalls when a miss needs a fill buffer and all four are in use.
// - a preload hint takes a fill buffer and counts against the same limit.
// - a preload hint never marks any register as busy.
// - a store stalls once eight write buffers are pending.
// - a load miss that evicts a dirty line takes write buffers for its write-backs.
// - a preload that would fault or walk the tables is dropped without effect.
// - write buffers are eight half-line entries and four pending buffers exist.
// - a later read or write to a line being filled takes a pending buffer, not a fill.
module lusc_interlock
	import lusc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic issueValid,
	input wire logic issueIsLoad,
	input wire logic issueIsPreload,
	input wire logic issueIsStore,
	input wire lusc_reg_t issueDestReg,
	input wire logic srcAUse,
	input wire lusc_reg_t srcAReg,
	input wire logic srcBUse,
	input wire lusc_reg_t srcBReg,
	input wire lusc_line_t issueLineAddr,
	input wire logic cacheHit,
	input wire logic preloadFault,
	input wire logic [1:0] evictDirty,
	input wire logic fillDone,
	input wire lusc_slot_t fillDoneSlot,
	input wire logic wbDrain,
	output logic issueStall,
	output logic [`LUSC_NUM_REGS-1:0] regBusy,
	output logic hitResultValid,
	output lusc_reg_t hitResultReg,
	output logic fillReqValid,
	output lusc_line_t fillReqAddr,
	output lusc_slot_t fillReqSlot,
	output logic wbReqValid,
	output logic [1:0] wbReqCount
);

	lusc_ctl_st_t st_q;
	lusc_ctl_st_t st_d;

	logic [`LUSC_FILL_BUFS-1:0] slotValid;
	logic [`LUSC_FILL_BUFS-1:0] slotMatch;
	logic [`LUSC_FILL_BUFS-1:0] slotAlloc;
	logic [`LUSC_FILL_BUFS-1:0] slotPend;
	logic [`LUSC_FILL_BUFS-1:0] slotDone;
	lusc_pend_t slotPendCnt [`LUSC_FILL_BUFS];

	logic anyMatch;
	lusc_slot_t matchSlot;
	logic freeAvail;
	lusc_slot_t freeSlot;
	logic [2:0] pendTotal;
	logic [2:0] fillsUsed;
	logic hazard;
	logic dropPreload;
	logic loadLike;
	logic needFill;
	logic needPend;
	lusc_wbcnt_t wbNeed;
	logic accepted;

	genvar g;
	generate
		for (g = 0; g < `LUSC_FILL_BUFS; g++)
		begin : gSlot
			lusc_fill_slot uSlot (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.alloc(slotAlloc[g]),
				.allocAddr(issueLineAddr),
				.lookupAddr(issueLineAddr),
				.pendAdd(slotPend[g]),
				.done(slotDone[g]),
				.valid(slotValid[g]),
				.match(slotMatch[g]),
				.pendCnt(slotPendCnt[g])
			);
			assign slotDone[g] = fillDone && (fillDoneSlot == 2'(g));
			assign slotAlloc[g] = accepted && needFill && (freeSlot == 2'(g));
			assign slotPend[g] = accepted && needPend && (matchSlot == 2'(g));
		end
	endgenerate

	// lowest free slot wins; a slot freed this cycle is only reused next cycle
	always_comb
	begin
		anyMatch = 1'b0;
		matchSlot = '0;
		freeAvail = 1'b0;
		freeSlot = '0;
		pendTotal = '0;
		fillsUsed = '0;
		for (int i = `LUSC_FILL_BUFS - 1; i >= 0; i--)
		begin
			if (slotMatch[i])
			begin
				anyMatch = 1'b1;
				matchSlot = 2'(i);
			end
			if (!slotValid[i])
			begin
				freeAvail = 1'b1;
				freeSlot = 2'(i);
			end
			pendTotal = pendTotal + slotPendCnt[i];
			fillsUsed = fillsUsed + {2'h0, slotValid[i]};
		end
	end

	always_comb
	begin
		for (int i = 0; i < `LUSC_NUM_REGS; i++)
			regBusy[i] = (st_q.hitCnt[i] != 2'h0) || st_q.missBusy[i];
	end

	always_comb
	begin
		hazard = (srcAUse && regBusy[srcAReg]) || (srcBUse && regBusy[srcBReg])
			|| (issueIsLoad && regBusy[issueDestReg]);
		dropPreload = issueIsPreload && preloadFault;
		loadLike = issueIsLoad || (issueIsPreload && !preloadFault);
		needFill = loadLike && !cacheHit && !anyMatch;
		needPend = anyMatch && ((issueIsLoad && !cacheHit) || issueIsStore);
		wbNeed = {3'h0, issueIsStore} + (needFill ? {2'h0, evictDirty} : 4'h0);
		issueStall = issueValid && (hazard
			|| (needFill && !freeAvail)
			|| (needPend && pendTotal >= 3'(`LUSC_PEND_BUFS))
			// a load pended on a line that finishes this cycle would leave its destination busy
			|| (needPend && slotDone[matchSlot])
			|| ((st_q.wbCount + wbNeed) > 4'(`LUSC_WR_BUFS)));
		accepted = issueValid && !issueStall;
	end

	always_comb
	begin
		st_d = st_q;
		st_d.fillReqValid = 1'b0;
		st_d.wbReqValid = 1'b0;
		st_d.hitResultValid = 1'b0;
		for (int i = 0; i < `LUSC_NUM_REGS; i++)
		begin
			if (st_q.hitCnt[i] != 2'h0)
				st_d.hitCnt[i] = st_q.hitCnt[i] - 2'h1;
			if (st_q.hitCnt[i] == 2'h1)
			begin
				st_d.hitResultValid = 1'b1;
				st_d.hitResultReg = 4'(i);
			end
			if (fillDone && st_q.missTag[i] == fillDoneSlot)
				st_d.missBusy[i] = 1'b0;
		end
		if (accepted && issueIsLoad && !dropPreload)
		begin
			if (cacheHit)
				st_d.hitCnt[issueDestReg] = 2'(`LUSC_USE_STALL);
			else
			begin
				// set after the clear so a same-cycle fill completion cannot lose it
				st_d.missBusy[issueDestReg] = 1'b1;
				st_d.missTag[issueDestReg] = needFill ? freeSlot : matchSlot;
			end
		end
		if (accepted && needFill)
		begin
			st_d.fillReqValid = 1'b1;
			st_d.fillReqAddr = issueLineAddr;
			st_d.fillReqSlot = freeSlot;
		end
		if (accepted && wbNeed != 4'h0)
		begin
			st_d.wbReqValid = 1'b1;
			st_d.wbReqCount = 2'(wbNeed);
		end
		// a drain with nothing pending is ignored so the count cannot wrap
		st_d.wbCount = st_q.wbCount + (accepted ? wbNeed : 4'h0)
			- ((wbDrain && st_q.wbCount != 4'h0) ? 4'h1 : 4'h0);
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign hitResultValid = st_q.hitResultValid;
	assign hitResultReg = st_q.hitResultReg;
	assign fillReqValid = st_q.fillReqValid;
	assign fillReqAddr = st_q.fillReqAddr;
	assign fillReqSlot = st_q.fillReqSlot;
	assign wbReqValid = st_q.wbReqValid;
	assign wbReqCount = st_q.wbReqCount;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	hitLatency_a: assert property (
		(accepted && issueIsLoad && cacheHit) |-> ##3 (hitResultValid
			&& hitResultReg == $past(issueDestReg, 3)))
		else $error("hit load result not ready three cycles after issue");

	hitUseStall_a: assert property (
		(accepted && issueIsLoad && cacheHit) ##1 (issueValid && srcAUse
			&& srcAReg == $past(issueDestReg)) |-> issueStall)
		else $error("dependent instruction issued right after hit load");

	missBusy_a: assert property (
		(accepted && issueIsLoad && !cacheHit) |=> regBusy[$past(issueDestReg)])
		else $error("missing load destination not held busy");

	fillReq_a: assert property (
		(accepted && needFill) |=> (fillReqValid && fillReqSlot == $past(freeSlot)
			&& slotValid[fillReqSlot]))
		else $error("miss did not claim a fill buffer");

	fillFull_a: assert property (
		(issueValid && needFill && fillsUsed == 3'h4) |-> issueStall)
		else $error("miss issued with all fill buffers busy");

	preloadFill_a: assert property (
		(accepted && issueIsPreload && !preloadFault && !cacheHit && !anyMatch)
			|=> fillReqValid)
		else $error("preload did not claim a fill buffer");

	preloadNoReg_a: assert property (
		(accepted && issueIsPreload && !issueIsLoad) |=> (regBusy & ~$past(regBusy)) == '0)
		else $error("preload marked a register busy");

	preloadDrop_a: assert property (
		(accepted && issueIsPreload && preloadFault) |=> !fillReqValid && !wbReqValid)
		else $error("faulting preload was not dropped");

	wbLimit_a: assert property (
		(issueValid && issueIsStore && st_q.wbCount == 4'h8) |-> issueStall)
		else $error("store issued with all write buffers pending");

	wbBound_a: assert property (
		st_q.wbCount <= 4'(`LUSC_WR_BUFS))
		else $error("write buffer count above its depth");

	evictWb_a: assert property (
		(accepted && needFill && evictDirty == 2'h2 && !issueIsStore && !wbDrain)
			|=> st_q.wbCount == $past(st_q.wbCount) + 4'h2)
		else $error("dirty eviction did not take write buffers");

	pendFull_a: assert property (
		(issueValid && needPend && pendTotal == 3'h4) |-> issueStall)
		else $error("pending buffer overrun");

	fillFree_a: assert property (
		(fillDone && slotValid[fillDoneSlot]) |=> !slotValid[$past(fillDoneSlot)])
		else $error("fill buffer not released after completion");

	hitStall_c: cover property (
		(accepted && issueIsLoad && cacheHit) ##1 issueStall [*2] ##1 accepted);
	fillFull_c: cover property (issueValid && needFill && !freeAvail);
	wbFull_c: cover property (st_q.wbCount == 4'h8 ##1 wbDrain);

endmodule

`default_nettype wire

// file: src/lusc_cfg.svh
/*
 * Sizes, limits and cycle counts for the load-use and buffer stall control.
 * Assumes a 50 MHz core clock; the latency figures are in core clock cycles.
 */
`ifndef LUSC_CFG_SVH
`define LUSC_CFG_SVH

`define LUSC_NUM_REGS 16
`define LUSC_FILL_BUFS 4
`define LUSC_PEND_BUFS 4
`define LUSC_WR_BUFS 8
`define LUSC_HIT_LATENCY 3
`define LUSC_USE_STALL (`LUSC_HIT_LATENCY - 1)
`define LUSC_LINE_AW 27

`endif

// file: src/lusc_pkg.sv
/*
 * Types shared by the stall control and its fill buffer slots.
 * Assumes lusc_cfg.svh is on the include path.
 */
`include "lusc_cfg.svh"

package lusc_pkg;

	typedef logic [3:0] lusc_reg_t;
	typedef logic [1:0] lusc_slot_t;
	typedef logic [`LUSC_LINE_AW-1:0] lusc_line_t;
	typedef logic [2:0] lusc_pend_t;
	typedef logic [3:0] lusc_wbcnt_t;

	typedef struct packed {
		logic valid;
		lusc_line_t addr;
		lusc_pend_t pendCnt;
	} lusc_fill_st_t;

	typedef struct packed {
		logic [`LUSC_NUM_REGS-1:0][1:0] hitCnt;
		logic [`LUSC_NUM_REGS-1:0] missBusy;
		logic [`LUSC_NUM_REGS-1:0][1:0] missTag;
		lusc_wbcnt_t wbCount;
		logic fillReqValid;
		lusc_line_t fillReqAddr;
		lusc_slot_t fillReqSlot;
		logic wbReqValid;
		logic [1:0] wbReqCount;
		logic hitResultValid;
		lusc_reg_t hitResultReg;
	} lusc_ctl_st_t;

endpackage

// file: src/lusc_fill_slot.sv
/*
 * One fill buffer entry: the line being fetched and the pending buffers
 * attached to it. Assumes alloc only reaches a free entry and done only
 * a busy one.
 */
`timescale 1ns/1ps
`default_nettype none

module lusc_fill_slot
	import lusc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic alloc,
	input wire lusc_line_t allocAddr,
	input wire lusc_line_t lookupAddr,
	input wire logic pendAdd,
	input wire logic done,
	output logic valid,
	output logic match,
	output lusc_pend_t pendCnt
);

	lusc_fill_st_t st_q;
	lusc_fill_st_t st_d;

	always_comb
	begin
		st_d = st_q;
		if (done)
		begin
			st_d.valid = 1'b0;
			st_d.pendCnt = '0;
		end
		if (alloc)
		begin
			st_d.valid = 1'b1;
			st_d.addr = allocAddr;
			st_d.pendCnt = '0;
		end
		else if (pendAdd && !done)
			st_d.pendCnt = st_q.pendCnt + 3'h1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign valid = st_q.valid;
	assign match = st_q.valid && (st_q.addr == lookupAddr);
	assign pendCnt = st_q.pendCnt;

endmodule

`default_nettype wire

// file: dv/lusc_mem_model.sv
/*
 * Memory side model: answers line fill requests after a set delay and
 * drains claimed write buffers one per cycle.
 * Assumes requests arrive as one-cycle pulses on sys_clk; the holds
 * come from the bench to keep buffers busy.
 */
`timescale 1ns/1ps
`default_nettype none

module lusc_mem_model
#(
	parameter int FILL_LAT = 6
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic fillHold,
	input wire logic wbHold,
	input wire logic fillReqValid,
	input wire logic [1:0] fillReqSlot,
	input wire logic wbReqValid,
	input wire logic [1:0] wbReqCount,
	output logic fillDone,
	output logic [1:0] fillDoneSlot,
	output logic wbDrain
);
	int cnt[4];
	int wbPend;
	int pick;
	logic drainNow;

	initial
	begin
		fillDone = 1'b0;
		fillDoneSlot = 2'h0;
		wbDrain = 1'b0;
	end

	always @(negedge sys_clk)
	begin
		pick = -1;
		drainNow = 1'b0;
		if (!rst_n)
		begin
			cnt = '{default: 0};
			wbPend = 0;
		end
		else
		begin
			for (int s = 0; s < 4; s++)
				if (!fillHold && cnt[s] == 1 && pick < 0)
					pick = s;
			if (pick >= 0)
				cnt[pick] = 0;
			for (int s = 0; s < 4; s++)
				if (!fillHold && cnt[s] > 1)
					cnt[s]--;
			if (fillReqValid)
				cnt[fillReqSlot] = FILL_LAT;
			drainNow = !wbHold && wbPend > 0;
			if (drainNow)
				wbPend--;
			if (wbReqValid)
				wbPend += wbReqCount;
		end
		fillDone <= (pick >= 0);
		// idle qualifier must not keep showing the last slot
		fillDoneSlot <= (pick >= 0) ? 2'(pick) : ~fillDoneSlot;
		wbDrain <= drainNow;
	end
endmodule

`default_nettype wire

// file: dv/lusc_interlock_tb.sv
/*
 * Self-checking bench for the issue interlock.
 * Assumes lusc_cfg.svh on the include path and the memory model beside it.
 */
`timescale 1ns/1ps
`default_nettype none

`include "lusc_cfg.svh"

module lusc_interlock_tb
	import lusc_pkg::*;
;
	localparam logic [2:0] LD = 3'h4;
	localparam logic [2:0] PL = 3'h2;
	localparam logic [2:0] ST = 3'h1;
	localparam logic [2:0] AL = 3'h0;
	logic sys_clk, rst_n, issueValid, issueIsLoad, issueIsPreload, issueIsStore;
	logic srcAUse, srcBUse, cacheHit, preloadFault, fillDone, wbDrain, issueStall;
	logic hitResultValid, fillReqValid, wbReqValid, fillHold, wbHold;
	lusc_reg_t issueDestReg, srcAReg, srcBReg, hitResultReg;
	lusc_line_t issueLineAddr, fillReqAddr;
	lusc_slot_t fillDoneSlot, fillReqSlot;
	logic [1:0] evictDirty, wbReqCount;
	logic [`LUSC_NUM_REGS-1:0] regBusy;
	logic [4:0] hitSeen;
	int nErrors, samplesChecked, fills, wbSum, stalls, f0;

	lusc_interlock i_lusc_interlock (.sys_clk, .rst_n, .issueValid, .issueIsLoad,
		.issueIsPreload, .issueIsStore, .issueDestReg, .srcAUse, .srcAReg, .srcBUse,
		.srcBReg, .issueLineAddr, .cacheHit, .preloadFault, .evictDirty, .fillDone,
		.fillDoneSlot, .wbDrain, .issueStall, .regBusy, .hitResultValid, .hitResultReg,
		.fillReqValid, .fillReqAddr, .fillReqSlot, .wbReqValid, .wbReqCount);

	lusc_mem_model i_lusc_mem_model (.sys_clk, .rst_n, .fillHold, .wbHold,
		.fillReqValid, .fillReqSlot, .wbReqValid, .wbReqCount, .fillDone,
		.fillDoneSlot, .wbDrain);

	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	always @(negedge sys_clk)
	begin
		if (fillReqValid)
			fills++;
		if (wbReqValid)
			wbSum += wbReqCount;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// leaves the request up after the taking edge so back-to-back stays legal
	task automatic go(input logic [2:0] k, input logic [3:0] d, input logic [9:0] a,
		input logic [7:0] ln, input logic h, input logic f, input logic [1:0] ev,
		input int lim);
		@(negedge sys_clk);
		{issueIsLoad, issueIsPreload, issueIsStore} = k;
		issueValid = 1'b1;
		issueDestReg = d;
		{srcBUse, srcBReg, srcAUse, srcAReg} = a;
		issueLineAddr = lusc_line_t'(ln);
		cacheHit = h;
		preloadFault = f;
		evictDirty = ev;
		#1;
		stalls = 0;
		while (issueStall !== 1'b0 && stalls < lim)
		begin
			@(negedge sys_clk);
			#1;
			stalls++;
		end
		hitSeen = {hitResultValid, hitResultReg};
		@(posedge sys_clk);
	endtask

	task automatic idle(input int n);
		@(negedge sys_clk);
		issueValid = 1'b0;
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic t_hit;
		go(LD, 4'h3, 5'h00, 8'h0a, 1'b1, 1'b0, 2'h0, 9);
		go(AL, 4'h1, 5'h13, 8'h00, 1'b0, 1'b0, 2'h0, 9);
		check(stalls, 2);
		check(hitSeen, 5'h13);
		go(LD, 4'h4, 10'h000, 8'h0b, 1'b1, 1'b0, 2'h0, 9);
		go(AL, 4'h1, 10'h280, 8'h00, 1'b0, 1'b0, 2'h0, 9);
		check(stalls, 2);
		check(hitSeen, 5'h14);
		idle(2);
	endtask

	task automatic t_miss;
		fillHold = 1'b1;
		f0 = fills;
		for (int i = 0; i < 3; i++)
			go(LD, 4'(5 + i), 5'h00, 8'(20 + i), 1'b0, 1'b0, 2'h0, 9);
		go(PL, 4'h8, 5'h00, 8'h17, 1'b0, 1'b0, 2'h0, 9);
		idle(1);
		check(fills - f0, 4);
		check({regBusy[5], regBusy[8]}, 2'h2);
		check(fillReqAddr, 27'h17);
		check(fillReqSlot, 2'h3);
		go(LD, 4'h9, 5'h00, 8'h14, 1'b0, 1'b0, 2'h0, 5);
		check(stalls, 0);
		for (int i = 0; i < 3; i++)
			go(LD, 4'(11 + i), 10'h000, 8'h15, 1'b0, 1'b0, 2'h0, 5);
		check(stalls, 0);
		go(LD, 4'he, 10'h000, 8'h16, 1'b0, 1'b0, 2'h0, 3);
		check(stalls, 3);
		go(LD, 4'ha, 5'h00, 8'h18, 1'b0, 1'b0, 2'h0, 3);
		check(stalls, 3);
		fillHold = 1'b0;
		go(LD, 4'ha, 5'h00, 8'h18, 1'b0, 1'b0, 2'h0, 60);
		check(stalls < 60, 1);
		idle(40);
		check(regBusy, 0);
	endtask

	task automatic t_store;
		wbHold = 1'b1;
		f0 = wbSum;
		for (int i = 0; i < 8; i++)
			go(ST, 4'h0, 5'h00, 8'(40 + i), 1'b1, 1'b0, 2'h0, 5);
		check(stalls, 0);
		go(ST, 4'h0, 5'h00, 8'h30, 1'b1, 1'b0, 2'h0, 3);
		check(stalls, 3);
		wbHold = 1'b0;
		go(ST, 4'h0, 5'h00, 8'h30, 1'b1, 1'b0, 2'h0, 40);
		idle(20);
		check(wbSum - f0, 9);
		f0 = wbSum;
		go(LD, 4'hb, 5'h00, 8'h31, 1'b0, 1'b0, 2'h2, 9);
		idle(20);
		check(wbSum - f0, 2);
	endtask

	task automatic t_fault;
		f0 = fills;
		go(PL, 4'hc, 5'h00, 8'h32, 1'b0, 1'b1, 2'h0, 5);
		go(AL, 4'h2, 5'h00, 8'h00, 1'b0, 1'b0, 2'h0, 5);
		idle(10);
		check({fills - f0, regBusy}, 0);
	endtask

	task close_out;
		if (nErrors == 0 && samplesChecked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		#100us;
		nErrors++;
		close_out;
	end

	initial
	begin
		{issueValid, issueIsLoad, issueIsPreload, issueIsStore, cacheHit} = 5'h00;
		{srcAUse, srcBUse, preloadFault, fillHold, wbHold} = 5'h00;
		{issueDestReg, srcAReg, srcBReg, evictDirty} = 14'h0000;
		issueLineAddr = '0;
		rst_n = 1'b0;
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		t_hit;
		t_miss;
		t_store;
		t_fault;
		close_out;
	end
endmodule

`default_nettype wire
